// ### sat_consts.vh
`ifndef SAT_CONSTS_VH
`define SAT_CONSTS_VH

// Event type register encoding (index in CRm[1:0] and op2)
`define SAT_EVT_OP0 2'h3
`define SAT_EVT_OP1 3'h3
`define SAT_EVT_CRN 4'hE
`define SAT_EVT_CRM_HI 2'h3

// Other system register encodings, {op0,op1,crn,crm,op2}
`define SAT_ENC_WINDOW 16'hDCE9
`define SAT_ENC_SCR 16'hF088
`define SAT_ENC_TPID2 16'hDE85
`define SAT_ENC_RND 16'hD920
`define SAT_ENC_RNDRS 16'hD921
`define SAT_ENC_HCRX 16'hE112

// Counter counts
`define SAT_IMPL_COUNTERS 5'h08
`define SAT_IDX_W 5

// Feature presence
`define SAT_HAS_EL3 1'b1
`define SAT_HAS_RME 1'b1
`define SAT_HAS_SME 1'b1
`define SAT_HAS_RNG_TRAP 1'b1
`define SAT_HAS_RNG 1'b0
`define SAT_HAS_HCX 1'b1
`define SAT_EL3_PRIO_SDD 1'b0

// Secure configuration field positions
`define SAT_SCR_NSE 62
`define SAT_SCR_GPF 48
`define SAT_SCR_THREAD_POINTER2_ACCESS 41
`define SAT_SCR_RANDOM_READ_TRAP 40
`define SAT_SCR_EXT_HYP_CONFIG_ACCESS 38
`define SAT_SCR_NS 0
`define SAT_SCR_RST 64'h0000000000000000

// Exception class and answer codes
`define SAT_EC_SYSREG 6'h18
`define SAT_ST_DONE 2'h0
`define SAT_ST_TRAP 2'h1
`define SAT_ST_UNDEF 2'h2
`define SAT_RND_ON 4'h1
`define SAT_RND_OFF 4'h0

// Read data sources
`define SAT_SRC_ZERO 2'h0
`define SAT_SRC_MEM 2'h1
`define SAT_SRC_REG 2'h2

`endif

// ### sat_evtype_mem.v
`timescale 1ns/1ps
`default_nettype none

module sat_evtype_mem (
    input wire clk_sys_in,
    input wire wr_en_in,
    input wire [4:0] wr_addr_in,
    input wire [31:0] wr_data_in,
    input wire [4:0] rd_addr_in,
    output wire [31:0] rd_data_out
);

    reg [31:0] mem [0:31];
    reg [31:0] rd_data_ff;

    // Read port leaves straight from its register
    assign rd_data_out = rd_data_ff;

    // Write port, then registered read of the old value
    always @(posedge clk_sys_in) begin
        if (wr_en_in) begin
            mem[wr_addr_in] <= wr_data_in;
        end
        rd_data_ff <= mem[rd_addr_in];
    end

endmodule // sat_evtype_mem

`default_nettype wire

// ### sat_trap_unit.v
// Functional notes
// - Event type registers also reachable via the window, counter select gives index.
// - With fine traps: index past implemented is undefined, else traps to EL2.
// - Without fine traps, out-of-range index takes one permitted outcome.
// - EL0 access needs user access enable, else trap to EL1 class 0x18.
// - Accessible count is hypervisor limit at EL0/EL1 when EL2 enabled.
// - Decode op0 3, op1 3, CRn 14, CRm 3:n[4:3], op2 n[2:0].
// - Fine-grained write trap bit sends EL0/EL1 access to EL2, class 0x18.
// - Hypervisor monitor trap sends EL0/EL1 access to EL2, class 0x18.
// - EL3 monitor trap sends accesses below EL3 to EL3, class 0x18.
// - Halted with secure debug disabled turns EL3 traps undefined.
// - At EL3 the write always completes into the selected register.
// - Secure configuration exists only with EL3, otherwise undefined.
// - Security state of EL2 and below from bits 62 and nonsecure select.
// - Granule fault route bit 48 routes EL0-EL2 granule faults to EL3.
// - Thread pointer 2 access bit 41 clear traps thread id 2 accesses to EL3.
// - Random read trap bit 40 sets isa field and traps random reads.
// - Warm reset clears random read trap bit.
// - Ext hyp config access bit 38 clear traps EL2 access, zero indirect reads.
`timescale 1ns/1ps
`default_nettype none

`include "sat_consts.vh"

module sat_trap_unit (
    input wire clk_sys_in,
    input wire srst_in,
    input wire req_valid_in,
    input wire req_write_in,
    input wire [1:0] req_op0_in,
    input wire [2:0] req_op1_in,
    input wire [3:0] req_crn_in,
    input wire [3:0] req_crm_in,
    input wire [2:0] req_op2_in,
    input wire [63:0] req_wdata_in,
    input wire [1:0] cur_el_in,
    input wire el2_enabled_in,
    input wire fine_traps_impl_in,
    input wire fine_trap_enable_in,
    input wire fine_grained_write_trap_in,
    input wire hypervisor_monitor_trap_in,
    input wire el3_monitor_trap_in,
    input wire [4:0] hypervisor_counter_limit_in,
    input wire [4:0] counter_select_field_in,
    input wire user_access_enable_in,
    input wire [1:0] host_mode_bits_in,
    input wire halted_in,
    input wire secure_debug_disabled_in,
    input wire [63:0] random_value_in,
    input wire [63:0] ext_hyp_config_reg_in,
    input wire granule_fault_in,
    input wire [1:0] granule_fault_el_in,
    output wire resp_valid_out,
    output wire [1:0] resp_status_out,
    output wire [1:0] resp_trap_el_out,
    output wire [5:0] resp_ec_out,
    output wire [63:0] resp_rdata_out,
    output wire [1:0] security_state_out,
    output wire granule_fault_route_out,
    output wire gpc_to_el3_out,
    output wire thread_pointer2_access_out,
    output wire [3:0] isa_random_field_out,
    output wire [63:0] ext_hyp_config_eff_out
);

    ////////////////////////////////////////////////////////////////////////
    // Register state

    reg [63:0] scr_ff;
    reg s1_valid_ff, s2_valid_ff;
    reg [1:0] s1_status_ff, s2_status_ff;
    reg [1:0] s1_el_ff, s2_el_ff;
    reg [5:0] s2_ec_ff;
    reg [1:0] s1_src_ff;
    reg [63:0] s1_data_ff, s2_rdata_ff;
    reg gpc_ff;
    reg [3:0] isa_rnd_ff;
    reg [63:0] hcrx_eff_ff;
    wire [31:0] mem_rdata;

    ////////////////////////////////////////////////////////////////////////
    // Decode

    wire [15:0] enc = {req_op0_in, req_op1_in, req_crn_in, req_crm_in, req_op2_in};
    wire is_evt_direct = (req_op0_in == `SAT_EVT_OP0) && (req_op1_in == `SAT_EVT_OP1) &&
        (req_crn_in == `SAT_EVT_CRN) && (req_crm_in[3:2] == `SAT_EVT_CRM_HI);
    // Window form reuses the same storage as the direct form
    wire is_evt_window = (enc == `SAT_ENC_WINDOW);
    wire is_evt = is_evt_direct || is_evt_window;
    // Index from encoding or from the counter select field
    wire [4:0] evt_idx = is_evt_direct ? {req_crm_in[1:0], req_op2_in}
                                       : counter_select_field_in;
    // Levels under the hypervisor's counter and trap controls
    wire low_el = (cur_el_in == 2'h0) || (cur_el_in == 2'h1);
    wire el3_tpm = `SAT_HAS_EL3 && el3_monitor_trap_in;
    // Fewer counters are visible when the hypervisor limits them
    wire [4:0] acc_count = (el2_enabled_in && low_el) ? hypervisor_counter_limit_in
                                                      : `SAT_IMPL_COUNTERS;

    // Writable fields; absent features stay zero
    wire [63:0] scr_wmask = ({63'h0, 1'b1} << `SAT_SCR_NS) |
        ({63'h0, `SAT_HAS_RME} << `SAT_SCR_NSE) |
        ({63'h0, `SAT_HAS_RME} << `SAT_SCR_GPF) |
        ({63'h0, `SAT_HAS_SME} << `SAT_SCR_THREAD_POINTER2_ACCESS) |
        ({63'h0, `SAT_HAS_RNG_TRAP} << `SAT_SCR_RANDOM_READ_TRAP) |
        ({63'h0, `SAT_HAS_HCX} << `SAT_SCR_EXT_HYP_CONFIG_ACCESS);

    ////////////////////////////////////////////////////////////////////////
    // Access decision

    reg [1:0] nxt_status;
    reg [1:0] nxt_el;
    reg [1:0] nxt_src;
    reg [63:0] nxt_data;
    reg evt_wr;
    reg scr_wr;

    // Priority chain mirrors the architectural check order per level
    always @* begin
        nxt_status = `SAT_ST_DONE;
        nxt_el = 2'h0;
        nxt_src = `SAT_SRC_ZERO;
        nxt_data = 64'h0;
        evt_wr = 1'b0;
        scr_wr = 1'b0;
        if (is_evt) begin
            if (cur_el_in == 2'h3) begin
                nxt_status = `SAT_ST_DONE;
            end else if (halted_in && secure_debug_disabled_in && `SAT_EL3_PRIO_SDD &&
                         el3_tpm) begin
                nxt_status = `SAT_ST_UNDEF;
            end else if ((cur_el_in == 2'h0) && !user_access_enable_in) begin
                nxt_status = `SAT_ST_TRAP;
                nxt_el = 2'h1;
            end else if (evt_idx >= `SAT_IMPL_COUNTERS) begin
                nxt_status = `SAT_ST_UNDEF;
            end else if (evt_idx >= acc_count) begin
                // Only reachable with EL2 enabled, so both cases trap to EL2
                nxt_status = `SAT_ST_TRAP;
                nxt_el = 2'h2;
            end else if (low_el && el2_enabled_in && fine_traps_impl_in &&
                         ((cur_el_in == 2'h1) || (host_mode_bits_in != 2'h3)) && // EL1 always, EL0 only when host mode bits are not 3
                         (!`SAT_HAS_EL3 || fine_trap_enable_in) &&
                         fine_grained_write_trap_in && req_write_in) begin
                nxt_status = `SAT_ST_TRAP;
                nxt_el = 2'h2;
            end else if (low_el && el2_enabled_in && hypervisor_monitor_trap_in) begin
                nxt_status = `SAT_ST_TRAP;
                nxt_el = 2'h2;
            end else if (el3_tpm) begin
                if (halted_in && secure_debug_disabled_in) begin
                    nxt_status = `SAT_ST_UNDEF;
                end else begin
                    nxt_status = `SAT_ST_TRAP;
                    nxt_el = 2'h3;
                end
            end
            // Only an access that survives every check may touch storage
            if (nxt_status == `SAT_ST_DONE) begin
                evt_wr = req_write_in;
                nxt_src = req_write_in ? `SAT_SRC_ZERO : `SAT_SRC_MEM;
            end
        end else if (enc == `SAT_ENC_SCR) begin
            if (!`SAT_HAS_EL3 || (cur_el_in != 2'h3)) begin
                nxt_status = `SAT_ST_UNDEF;
            end else begin
                scr_wr = req_write_in;
                nxt_src = `SAT_SRC_REG;
                nxt_data = req_write_in ? 64'h0 : scr_ff;
            end
        end else if (enc == `SAT_ENC_TPID2) begin
            if (!`SAT_HAS_SME) begin
                nxt_status = `SAT_ST_UNDEF;
            end else if ((cur_el_in != 2'h3) && !scr_ff[`SAT_SCR_THREAD_POINTER2_ACCESS]) begin
                nxt_status = `SAT_ST_TRAP;
                nxt_el = 2'h3;
            end
        end else if ((enc == `SAT_ENC_RND) || (enc == `SAT_ENC_RNDRS)) begin
            if (req_write_in) begin
                nxt_status = `SAT_ST_UNDEF;
            end else if (scr_ff[`SAT_SCR_RANDOM_READ_TRAP]) begin
                nxt_status = `SAT_ST_TRAP;
                nxt_el = 2'h3;
            end else if (!`SAT_HAS_RNG) begin
                nxt_status = `SAT_ST_UNDEF;
            end else begin
                nxt_src = `SAT_SRC_REG;
                nxt_data = random_value_in;
            end
        end else if (enc == `SAT_ENC_HCRX) begin
            if (!`SAT_HAS_HCX || low_el) begin
                nxt_status = `SAT_ST_UNDEF;
            end else if ((cur_el_in == 2'h2) && !scr_ff[`SAT_SCR_EXT_HYP_CONFIG_ACCESS]) begin
                nxt_status = `SAT_ST_TRAP;
                nxt_el = 2'h3;
            end else if (!req_write_in) begin
                nxt_src = `SAT_SRC_REG;
                nxt_data = ext_hyp_config_reg_in;
            end
        end else begin
            nxt_status = `SAT_ST_UNDEF;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Event type storage, read data registered inside

    sat_evtype_mem u_evt_mem (
        .clk_sys_in(clk_sys_in),
        .wr_en_in(req_valid_in && evt_wr),
        .wr_addr_in(evt_idx),
        .wr_data_in(req_wdata_in[31:0]),
        .rd_addr_in(evt_idx),
        .rd_data_out(mem_rdata)
    );

    ////////////////////////////////////////////////////////////////////////
    // Secure configuration register

    // Only trap bit has a defined warm reset; others cleared for determinism
    // Writes only land at EL3, as decided in the access chain
    always @(posedge clk_sys_in) begin
        if (srst_in) begin
            scr_ff <= `SAT_SCR_RST;
        end else if (req_valid_in && scr_wr) begin
            scr_ff <= req_wdata_in & scr_wmask;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Answer pipeline: decision stage then data stage

    always @(posedge clk_sys_in) begin
        if (srst_in) begin
            s1_valid_ff <= 1'b0;
            s1_status_ff <= `SAT_ST_DONE;
            s1_el_ff <= 2'h0;
            s1_src_ff <= `SAT_SRC_ZERO;
            s1_data_ff <= 64'h0;
            s2_valid_ff <= 1'b0;
            s2_status_ff <= `SAT_ST_DONE;
            s2_el_ff <= 2'h0;
            s2_ec_ff <= 6'h00;
            s2_rdata_ff <= 64'h0;
        end else begin
            s1_valid_ff <= req_valid_in;
            s1_status_ff <= nxt_status;
            s1_el_ff <= nxt_el;
            s1_src_ff <= nxt_src;
            s1_data_ff <= nxt_data;
            s2_valid_ff <= s1_valid_ff;
            s2_status_ff <= s1_status_ff;
            s2_el_ff <= s1_el_ff;
            // Class code registered so the port comes straight from a flop
            s2_ec_ff <= (s1_status_ff == `SAT_ST_TRAP) ? `SAT_EC_SYSREG : 6'h00;
            // Upper word of event type reads as zero
            case (s1_src_ff)
                `SAT_SRC_MEM: s2_rdata_ff <= {32'h0, mem_rdata};
                `SAT_SRC_REG: s2_rdata_ff <= s1_data_ff;
                default: s2_rdata_ff <= 64'h0;
            endcase
        end
    end

    // Answer ports are plain flop copies
    assign resp_valid_out = s2_valid_ff;
    assign resp_status_out = s2_status_ff;
    assign resp_trap_el_out = s2_el_ff;
    assign resp_ec_out = s2_ec_ff;
    assign resp_rdata_out = s2_rdata_ff;

    ////////////////////////////////////////////////////////////////////////
    // Control outputs derived from the secure configuration

    // Granule faults below EL3 route up only when enabled
    // The three registered ports lag the register by one cycle but stay glitch free
    always @(posedge clk_sys_in) begin
        if (srst_in) begin
            gpc_ff <= 1'b0;
            isa_rnd_ff <= `SAT_RND_OFF;
            hcrx_eff_ff <= 64'h0;
        end else begin
            gpc_ff <= granule_fault_in && (granule_fault_el_in != 2'h3) &&
                      scr_ff[`SAT_SCR_GPF];
            isa_rnd_ff <= (scr_ff[`SAT_SCR_RANDOM_READ_TRAP] || `SAT_HAS_RNG) ? `SAT_RND_ON
                                                                   : `SAT_RND_OFF;
            hcrx_eff_ff <= scr_ff[`SAT_SCR_EXT_HYP_CONFIG_ACCESS] ? ext_hyp_config_reg_in : 64'h0;
        end
    end

    // Encoding {EXTENDED_STATE_SELECT,NS}: 00 secure, 01 non-secure, 11 realm
    assign security_state_out = {scr_ff[`SAT_SCR_NSE], scr_ff[`SAT_SCR_NS]};
    assign granule_fault_route_out = scr_ff[`SAT_SCR_GPF];
    assign gpc_to_el3_out = gpc_ff;
    assign thread_pointer2_access_out = scr_ff[`SAT_SCR_THREAD_POINTER2_ACCESS];
    assign isa_random_field_out = isa_rnd_ff;
    assign ext_hyp_config_eff_out = hcrx_eff_ff;

endmodule // sat_trap_unit

`default_nettype wire

// ### sat_trap_props.sv
`timescale 1ns/1ps
`default_nettype none
module sat_trap_props (
    input wire logic clk_sys_in,
    input wire logic srst_in,
    input wire logic req_valid_in,
    input wire logic [1:0] req_op0_in,
    input wire logic [2:0] req_op1_in,
    input wire logic [3:0] req_crn_in,
    input wire logic [3:0] req_crm_in,
    input wire logic [2:0] req_op2_in,
    input wire logic [1:0] cur_el_in,
    input wire logic el2_enabled_in,
    input wire logic fine_grained_write_trap_in,
    input wire logic hypervisor_monitor_trap_in,
    input wire logic el3_monitor_trap_in,
    input wire logic [4:0] hypervisor_counter_limit_in,
    input wire logic user_access_enable_in,
    input wire logic halted_in,
    input wire logic secure_debug_disabled_in,
    input wire logic granule_fault_in,
    input wire logic [1:0] granule_fault_el_in,
    input wire logic resp_valid_out,
    input wire logic [1:0] resp_status_out,
    input wire logic [1:0] resp_trap_el_out,
    input wire logic [5:0] resp_ec_out,
    input wire logic granule_fault_route_out,
    input wire logic gpc_to_el3_out
);
    default clocking cb @(posedge clk_sys_in);
    endclocking
    default disable iff (srst_in);
    ////////////////////////////////////////////////////////////////
    // Event type request decode, index from CRm low bits and op2
    wire go = req_valid_in && req_op0_in == 2'h3 && req_op1_in == 3'h3 &&
        req_crn_in == 4'hE && req_crm_in[3:2] == 2'h3;
    wire [4:0] idx = {req_crm_in[1:0], req_op2_in};
    wire low_ok = idx < 5'h08 && !(cur_el_in == 2'h0 && !user_access_enable_in);
    wire m2 = go && cur_el_in == 2'h2 && idx < 5'h08 && el3_monitor_trap_in;
    wire sdd_h = halted_in && secure_debug_disabled_in;
    ////////////////////////////////////////////////////////////////
    lat_answer_a: assert property (req_valid_in |-> ##2 resp_valid_out)
        else $error("answer not two cycles after request");
    class_code_a: assert property (resp_valid_out |->
        resp_ec_out == ((resp_status_out == 2'h1) ? 6'h18 : 6'h00))
        else $error("exception class wrong");
    el3_done_a: assert property (go && cur_el_in == 2'h3 |-> ##2 resp_status_out == 2'h0)
        else $error("top level write not completed");
    user_trap_a: assert property (go && cur_el_in == 2'h0 && !user_access_enable_in
        |-> ##2 resp_status_out == 2'h1 && resp_trap_el_out == 2'h1)
        else $error("user access not trapped to level 1");
    range_undef_a: assert property (go && cur_el_in != 2'h3 && idx >= 5'h08 &&
        !(cur_el_in == 2'h0 && !user_access_enable_in) |-> ##2 resp_status_out == 2'h2)
        else $error("unimplemented index not undefined");
    limit_trap_a: assert property (go && cur_el_in == 2'h1 && el2_enabled_in && low_ok &&
        idx >= hypervisor_counter_limit_in |-> ##2 resp_status_out == 2'h1 && resp_trap_el_out == 2'h2)
        else $error("index past limit not trapped");
    hyp_trap_a: assert property (go && cur_el_in == 2'h1 && el2_enabled_in && low_ok &&
        idx < hypervisor_counter_limit_in && hypervisor_monitor_trap_in && !fine_grained_write_trap_in
        |-> ##2 resp_status_out == 2'h1 && resp_trap_el_out == 2'h2)
        else $error("monitor trap not to level 2");
    mon_trap_a: assert property (m2 && !sdd_h |-> ##2 resp_trap_el_out == 2'h3)
        else $error("monitor trap not to level 3");
    sdd_undef_a: assert property (m2 && sdd_h |-> ##2 resp_status_out == 2'h2)
        else $error("halted trap not undefined");
    gpc_route_a: assert property (granule_fault_in && granule_fault_route_out &&
        granule_fault_el_in != 2'h3 |=> gpc_to_el3_out)
        else $error("granule fault not routed");
endmodule // sat_trap_props
bind sat_trap_unit sat_trap_props u_props (.clk_sys_in, .srst_in, .req_valid_in, .req_op0_in,
    .req_op1_in, .req_crn_in, .req_crm_in, .req_op2_in, .cur_el_in, .el2_enabled_in,
    .fine_grained_write_trap_in, .hypervisor_monitor_trap_in, .el3_monitor_trap_in,
    .hypervisor_counter_limit_in, .user_access_enable_in, .halted_in, .secure_debug_disabled_in,
    .granule_fault_in, .granule_fault_el_in, .resp_valid_out, .resp_status_out,
    .resp_trap_el_out, .resp_ec_out, .granule_fault_route_out, .gpc_to_el3_out);
`default_nettype wire

// ### tb_top.sv
`timescale 1ns/1ps
`default_nettype none
`include "sat_consts.vh"
module tb_top;
    logic clk_sys_in = 1'b0, srst_in = 1'b1, req_valid_in = 1'b0, req_write_in = 1'b0;
    logic [1:0] req_op0_in = 2'h0, cur_el_in = 2'h3, host_mode_bits_in = 2'h0;
    logic [2:0] req_op1_in = 3'h0, req_op2_in = 3'h0;
    logic [3:0] req_crn_in = 4'h0, req_crm_in = 4'h0;
    logic [63:0] req_wdata_in = 64'h0, random_value_in = 64'h0, ext_hyp_config_reg_in = 64'h0;
    logic el2_enabled_in = 1'b0, fine_traps_impl_in = 1'b1, fine_trap_enable_in = 1'b1;
    logic fine_grained_write_trap_in = 1'b0, hypervisor_monitor_trap_in = 1'b0;
    logic el3_monitor_trap_in = 1'b0, user_access_enable_in = 1'b0, halted_in = 1'b0;
    logic secure_debug_disabled_in = 1'b0, granule_fault_in = 1'b0;
    logic [1:0] granule_fault_el_in = 2'h1;
    logic [4:0] hypervisor_counter_limit_in = 5'h08, counter_select_field_in = 5'h00;
    wire resp_valid_out, granule_fault_route_out, gpc_to_el3_out, thread_pointer2_access_out;
    wire [1:0] resp_status_out, resp_trap_el_out, security_state_out;
    wire [5:0] resp_ec_out;
    wire [3:0] isa_random_field_out;
    wire [63:0] resp_rdata_out, ext_hyp_config_eff_out;
    logic [73:0] q[$];
    logic [31:0] mem [8];
    integer failures = 0, total_checks = 0, cyc = 0, seed = 38, i;

    sat_trap_unit uut (.*);

    always #12.5 clk_sys_in = ~clk_sys_in;
    ////////////////////////////////////////////////////////////////
    task automatic results();
        $display("checks=%0d failures=%0d", total_checks, failures);
        if (failures == 0 && total_checks > 0) begin
            $display("All tests passed");
        end else begin
            $display("Some tests failed");
        end
        $finish;
    endtask
    task automatic chk(input logic [73:0] got, input logic [73:0] exp);
        total_checks = total_checks + 1;
        if (got !== exp) begin
            failures = failures + 1;
            $display("ERROR t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask
    // Request held through its taking edge; valid stays up for back-to-back use
    task automatic acc(input logic wr, input logic [15:0] e, input logic [63:0] d,
        input logic [1:0] st, input logic [1:0] tel, input logic [63:0] rd);
        req_write_in = wr;
        {req_op0_in, req_op1_in, req_crn_in, req_crm_in, req_op2_in} = e;
        req_wdata_in = d;
        req_valid_in = 1'b1;
        q.push_back({st, tel, (st == 2'h1) ? 6'h18 : 6'h00, rd});
        @(posedge clk_sys_in);
        #1;
    endtask
    task automatic idle(input int n);
        req_valid_in = 1'b0;
        repeat (n) @(posedge clk_sys_in);
        #1;
    endtask
    function automatic logic [15:0] ev(input logic [4:0] n);
        return {2'h3, 3'h3, 4'hE, 2'h3, n};
    endfunction
    ////////////////////////////////////////////////////////////////
    // Answers sampled mid-cycle, away from the launching edge
    always @(negedge clk_sys_in) begin
        cyc = cyc + 1;
        if (resp_valid_out === 1'b1) begin
            if (q.size() == 0) chk(74'h0, 74'h1);
            else chk({resp_status_out, resp_trap_el_out, resp_ec_out, resp_rdata_out}, q.pop_front());
        end
        if (cyc > 2000) begin
            failures = failures + 1;
            results();
        end
    end
    ////////////////////////////////////////////////////////////////
    initial begin
        repeat (3) @(posedge clk_sys_in);
        #1;
        srst_in = 1'b0;
        chk(74'({security_state_out, isa_random_field_out}), 74'h0);
        ext_hyp_config_reg_in = {$random(seed), $random(seed)};
        random_value_in = {$random(seed), $random(seed)};
        for (i = 0; i < 8; i++) begin
            mem[i] = $random(seed);
            acc(1'b1, ev(i[4:0]), {$random(seed), mem[i]}, 2'h0, 2'h0, 64'h0);
        end
        for (i = 0; i < 8; i++) begin
            counter_select_field_in = 5'(7 - i);
            acc(1'b0, ev(i[4:0]), 64'h0, 2'h0, 2'h0, {32'h0, mem[i]});
            acc(1'b0, `SAT_ENC_WINDOW, 64'h0, 2'h0, 2'h0, {32'h0, mem[7 - i]});
        end
        cur_el_in = 2'h0;
        acc(1'b0, ev(5'h2), 64'h0, 2'h1, 2'h1, 64'h0);
        user_access_enable_in = 1'b1;
        acc(1'b0, ev(5'h2), 64'h0, 2'h0, 2'h0, {32'h0, mem[2]});
        acc(1'b0, ev(5'h9), 64'h0, 2'h2, 2'h0, 64'h0);
        cur_el_in = 2'h1;
        el2_enabled_in = 1'b1;
        hypervisor_counter_limit_in = 5'h04;
        acc(1'b1, ev(5'h4), 64'h0, 2'h1, 2'h2, 64'h0);
        acc(1'b0, ev(5'h3), 64'h0, 2'h0, 2'h0, {32'h0, mem[3]});
        acc(1'b0, ev(5'h8), 64'h0, 2'h2, 2'h0, 64'h0);
        fine_grained_write_trap_in = 1'b1;
        acc(1'b1, ev(5'h1), 64'h0, 2'h1, 2'h2, 64'h0);
        host_mode_bits_in = 2'h3;
        acc(1'b1, ev(5'h1), 64'h0, 2'h1, 2'h2, 64'h0);
        cur_el_in = 2'h0;
        acc(1'b1, ev(5'h1), {32'h0, mem[1]}, 2'h0, 2'h0, 64'h0);
        cur_el_in = 2'h1;
        acc(1'b0, ev(5'h1), 64'h0, 2'h0, 2'h0, {32'h0, mem[1]});
        fine_trap_enable_in = 1'b0;
        acc(1'b1, ev(5'h1), {32'h0, mem[1]}, 2'h0, 2'h0, 64'h0);
        fine_grained_write_trap_in = 1'b0;
        hypervisor_monitor_trap_in = 1'b1;
        acc(1'b0, ev(5'h1), 64'h0, 2'h1, 2'h2, 64'h0);
        el2_enabled_in = 1'b0;
        acc(1'b0, ev(5'h6), 64'h0, 2'h0, 2'h0, {32'h0, mem[6]});
        el3_monitor_trap_in = 1'b1;
        acc(1'b0, ev(5'h6), 64'h0, 2'h1, 2'h3, 64'h0);
        cur_el_in = 2'h2;
        acc(1'b1, ev(5'h5), 64'h0, 2'h1, 2'h3, 64'h0);
        halted_in = 1'b1;
        secure_debug_disabled_in = 1'b1;
        acc(1'b1, ev(5'h5), 64'h0, 2'h2, 2'h0, 64'h0);
        cur_el_in = 2'h3;
        acc(1'b1, `SAT_ENC_SCR, '1, 2'h0, 2'h0, 64'h0);
        acc(1'b0, `SAT_ENC_SCR, 64'h0, 2'h0, 2'h0, 64'h4001_0340_0000_0001);
        idle(3);
        chk(74'({security_state_out, granule_fault_route_out, thread_pointer2_access_out,
            isa_random_field_out}), 74'hF1);
        chk(74'(ext_hyp_config_eff_out), 74'(ext_hyp_config_reg_in));
        cur_el_in = 2'h1;
        granule_fault_in = 1'b1;
        acc(1'b0, `SAT_ENC_RND, 64'h0, 2'h1, 2'h3, 64'h0);
        chk(74'(gpc_to_el3_out), 74'h1);
        granule_fault_in = 1'b0;
        acc(1'b0, `SAT_ENC_SCR, 64'h0, 2'h2, 2'h0, 64'h0);
        chk(74'(gpc_to_el3_out), 74'h0);
        acc(1'b1, `SAT_ENC_TPID2, 64'h0, 2'h0, 2'h0, 64'h0);
        cur_el_in = 2'h2;
        acc(1'b1, `SAT_ENC_HCRX, 64'h0, 2'h0, 2'h0, 64'h0);
        acc(1'b0, `SAT_ENC_HCRX, 64'h0, 2'h0, 2'h0, ext_hyp_config_reg_in);
        cur_el_in = 2'h3;
        acc(1'b1, `SAT_ENC_SCR, 64'h0, 2'h0, 2'h0, 64'h0);
        cur_el_in = 2'h1;
        acc(1'b0, `SAT_ENC_RNDRS, 64'h0, 2'h2, 2'h0, 64'h0);
        acc(1'b1, `SAT_ENC_TPID2, 64'h0, 2'h1, 2'h3, 64'h0);
        cur_el_in = 2'h2;
        acc(1'b1, `SAT_ENC_HCRX, 64'h0, 2'h1, 2'h3, 64'h0);
        idle(3);
        chk(74'({ext_hyp_config_eff_out, isa_random_field_out}), 74'h0);
        cur_el_in = 2'h3;
        acc(1'b1, `SAT_ENC_SCR, 64'h0000_0100_0000_0000, 2'h0, 2'h0, 64'h0);
        idle(3);
        chk(74'(isa_random_field_out), 74'h1);
        // Warm reset in mid-run must drop the random trap again
        srst_in = 1'b1;
        idle(2);
        srst_in = 1'b0;
        chk(74'(isa_random_field_out), 74'h0);
        chk(74'(q.size()), 74'h0);
        results();
    end
endmodule // tb_top
`default_nettype wire
